// File: verilog/timer_cfg.svh
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ****************************************************************
// register map (byte offsets on the plain register port)
// ****************************************************************
`define TMR_ADDR_W 3
`define TMR_OFS_MODE 3'h0
`define TMR_OFS_CTRL 3'h1
`define TMR_OFS_CLK 3'h2
`define TMR_OFS_LOW0 3'h3
`define TMR_OFS_HIGH0 3'h4
`define TMR_OFS_LOW1 3'h5
`define TMR_OFS_HIGH1 3'h6

// ****************************************************************
// field positions
// ****************************************************************
`define TMR_MODE_SLOT_W 4
`define TMR_CTRL_RUN0 0
`define TMR_CTRL_FLAG0 2
`define TMR_CLK_TURBO0 3

// ****************************************************************
// reset values
// ****************************************************************
`define TMR_RST_BYTE 8'h00
`define TMR_RST_PAIR 2'h0

// ****************************************************************
// machine cycle timing
// ****************************************************************
`define TMR_PH_THREE 2'h2
`define TMR_PH_FOUR 2'h3
`define TMR_DIV12_LAST 2'h2
`define TMR_DIV12_FIRST 2'h0

// ****************************************************************
// count limits
// ****************************************************************
`define TMR_LOW5_MAX 5'h1f
`define TMR_BYTE_MAX 8'hff
`define TMR_WORD_MAX 16'hffff

`endif

// File: verilog/timer_pkg.sv
package timer_pkg;

    // counting layout of one unit, encoded high select bit first
    typedef enum logic [1:0] {
        mode_13bit,
        mode_16bit,
        mode_reload8,
        mode_split
    } mode_e;

    // one unit's nibble of the mode configuration register
    typedef struct packed {
        logic gate;
        logic count_ext;
        mode_e mode;
    } unit_cfg_s;

    // next count of one unit and whether it rolled over
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic ovf;
    } cnt_next_s;

endpackage

// File: verilog/dual_timer.sv
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "timer_cfg.svh"

// How it works
// - timer function counts a time-base tick of clock/12 or clock/4
// - turbo select bit 1 picks clock/4, 0 picks clock/12; reset clears it
// - each count pin is sampled once per machine cycle at phase four
// - a high sample followed by a low sample counts as one falling edge
// - count registers step only at phase three of a machine cycle; software writes land on any clock
// - a recognised edge changes the count in the following machine cycle
// - config bit 2 (unit 0) and bit 6 (unit 1) choose ticks or pin edges
// - each unit has its own two mode-select bits, four modes
// - counting needs run bit set and gate bit clear or gate pin high; unit 1 skips its run bit while unit 0 is split
// - mode 0 is 13 bits: high byte plus low five bits of low byte
// - mode 0 carries into high byte from low bit 4; 1fff to 0 sets overflow
// - mode 1 counts all sixteen bits; ffff to 0 sets overflow
// - mode 2 low byte wraps, sets overflow, reloads from unchanged high byte
// - overflow flag set at phase three of the overflowing machine cycle
// - overflow flag cleared when processor vectors to that unit's routine
// - unit 1 in mode 3 holds its count frozen
// - unit 0 mode 3: two 8-bit counters, high uses unit 1 run and flag
module dual_timer
    import timer_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // register port
    input wire logic [`TMR_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // pins, bit 0 belongs to unit 0
    input wire logic [1:0] count_pin_i,
    input wire logic [1:0] ext_gate_pin_i,
    // processor vectoring to each unit's service routine
    input wire logic [1:0] vector_ack_i,
    // overflow flags toward the interrupt logic
    output logic [1:0] overflow_flag_o
);

    // ****************************************************************
    // machine cycle sequencing
    // ****************************************************************

    logic [1:0] phase_q;
    logic [1:0] div_q;
    logic [1:0] div_d;
    logic at_phase_three;
    logic at_phase_four;

    assign at_phase_three = (phase_q == `TMR_PH_THREE);
    assign at_phase_four = (phase_q == `TMR_PH_FOUR);
    // slow base repeats every three machine cycles, i.e. twelve clocks
    assign div_d = (div_q == `TMR_DIV12_LAST) ? `TMR_DIV12_FIRST : div_q + 2'h1;

    // four phases per machine cycle; the divide-by-three steps at its end
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_q <= `TMR_RST_PAIR;
            div_q <= `TMR_RST_PAIR;
        end else if (clk_en_i) begin
            phase_q <= phase_q + 2'h1;
            if (at_phase_four) begin
                div_q <= div_d;
            end
        end
    end

    // ****************************************************************
    // register port decode
    // ****************************************************************

    logic wr_mode;
    logic wr_ctrl;
    logic wr_clk;
    logic [1:0] wr_low;
    logic [1:0] wr_high;

    assign wr_mode = reg_wr_i && (reg_addr_i == `TMR_OFS_MODE);
    assign wr_ctrl = reg_wr_i && (reg_addr_i == `TMR_OFS_CTRL);
    assign wr_clk = reg_wr_i && (reg_addr_i == `TMR_OFS_CLK);
    assign wr_low[0] = reg_wr_i && (reg_addr_i == `TMR_OFS_LOW0);
    assign wr_high[0] = reg_wr_i && (reg_addr_i == `TMR_OFS_HIGH0);
    assign wr_low[1] = reg_wr_i && (reg_addr_i == `TMR_OFS_LOW1);
    assign wr_high[1] = reg_wr_i && (reg_addr_i == `TMR_OFS_HIGH1);

    // ****************************************************************
    // configuration registers
    // ****************************************************************

    logic [7:0] mode_cfg_q;
    logic [1:0] run_q;
    logic [1:0] turbo_q;
    logic unit0_split;

    // mode nibble per unit: gate, count select, two mode-select bits
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_cfg_q <= `TMR_RST_BYTE;
            run_q <= `TMR_RST_PAIR;
            turbo_q <= `TMR_RST_PAIR;
        end else if (clk_en_i) begin
            if (wr_mode) begin
                mode_cfg_q <= reg_wdata_i;
            end
            if (wr_ctrl) begin
                run_q <= reg_wdata_i[`TMR_CTRL_RUN0 +: 2];
            end
            if (wr_clk) begin
                turbo_q <= reg_wdata_i[`TMR_CTRL_RUN0 + `TMR_CLK_TURBO0 +: 2];
            end
        end
    end

    assign unit0_split = (mode_e'(mode_cfg_q[1:0]) == mode_split);

    // ****************************************************************
    // count step per mode
    // ****************************************************************

    // low-path increment; in split mode the high byte is left to its own path
    function automatic cnt_next_s count_step(mode_e m, logic [7:0] hi, logic [7:0] lo);
        cnt_next_s r;
        r.hi = hi;
        r.lo = lo;
        r.ovf = 1'b0;
        case (m)
            mode_13bit: begin
                // top three low bits are left alone
                r.lo = {lo[7:5], lo[4:0] + 5'h01};
                if (lo[4:0] == `TMR_LOW5_MAX) begin
                    r.hi = hi + 8'h01;
                    r.ovf = (hi == `TMR_BYTE_MAX);
                end
            end
            mode_16bit: begin
                {r.hi, r.lo} = {hi, lo} + 16'h0001;
                r.ovf = ({hi, lo} == `TMR_WORD_MAX);
            end
            mode_reload8: begin
                if (lo == `TMR_BYTE_MAX) begin
                    r.lo = hi;
                    r.ovf = 1'b1;
                end else begin
                    r.lo = lo + 8'h01;
                end
            end
            mode_split: begin
                r.lo = lo + 8'h01;
                r.ovf = (lo == `TMR_BYTE_MAX);
            end
            default: begin
                r.ovf = 1'b0;
            end
        endcase
        return r;
    endfunction

    // ****************************************************************
    // per-unit counting
    // ****************************************************************

    logic [7:0] lo_q [2];
    logic [7:0] hi_q [2];
    logic [1:0] low_ovf;
    logic [1:0] high_alt_ovf;
    logic [1:0] set_flag;
    logic [1:0] flag_q;

    for (genvar u = 0; u < 2; u++) begin : g_unit
        unit_cfg_s cfg;
        cnt_next_s nx;
        logic sample_q;
        logic edge_q;
        logic edge_seen;
        logic tb_tick;
        logic gate_ok;
        logic run_ok;
        logic frozen;
        logic low_inc;
        logic high_alt;
        logic [7:0] lo_d;
        logic [7:0] hi_d;
        logic flag_d;

        assign cfg = unit_cfg_s'(mode_cfg_q[u*`TMR_MODE_SLOT_W +: `TMR_MODE_SLOT_W]);
        // machine-cycle tick, every cycle in turbo, every third otherwise
        assign tb_tick = at_phase_three && (turbo_q[u] || div_q == `TMR_DIV12_FIRST);
        // high in the previous cycle's sample, low now
        assign edge_seen = at_phase_four && sample_q && !count_pin_i[u];
        assign gate_ok = !cfg.gate || ext_gate_pin_i[u];
        // with unit 0 split, unit 1 loses its run bit to unit 0's high byte
        assign run_ok = (u == 1 && unit0_split) ? 1'b1 : run_q[u];
        assign frozen = (u == 1) && (cfg.mode == mode_split);
        assign low_inc = at_phase_three && run_ok && gate_ok && !frozen
            && (cfg.count_ext ? edge_q : tb_tick);
        // unit 0 high byte in split mode: ticks only, gated by unit 1 run
        assign high_alt = (u == 0) && unit0_split && tb_tick && run_q[1];
        assign nx = count_step(cfg.mode, hi_q[u], lo_q[u]);
        // a software write beats a count landing in the same clock
        assign lo_d = wr_low[u] ? reg_wdata_i : (low_inc ? nx.lo : lo_q[u]);
        assign hi_d = wr_high[u] ? reg_wdata_i
            : (high_alt ? hi_q[u] + 8'h01 : (low_inc ? nx.hi : hi_q[u]));
        assign low_ovf[u] = low_inc && nx.ovf;
        assign high_alt_ovf[u] = high_alt && (hi_q[u] == `TMR_BYTE_MAX);
        // a fresh overflow wins over a clear in the same clock
        assign flag_d = set_flag[u] || ((wr_ctrl ? reg_wdata_i[`TMR_CTRL_FLAG0 + u]
            : flag_q[u]) && !vector_ack_i[u]);

        // pin sample and edge memory; the edge waits for next phase three
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                sample_q <= 1'b0;
                edge_q <= 1'b0;
            end else if (clk_en_i) begin
                if (at_phase_four) begin
                    sample_q <= count_pin_i[u];
                    edge_q <= edge_seen;
                end
            end
        end

        // count bytes and overflow flag; counts and flag sets land at phase three
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                lo_q[u] <= `TMR_RST_BYTE;
                hi_q[u] <= `TMR_RST_BYTE;
                flag_q[u] <= 1'b0;
            end else if (clk_en_i) begin
                lo_q[u] <= lo_d;
                hi_q[u] <= hi_d;
                flag_q[u] <= flag_d;
            end
        end
    end

    // unit 1's flag belongs to unit 0's high byte while unit 0 is split
    assign set_flag[0] = low_ovf[0];
    assign set_flag[1] = unit0_split ? high_alt_ovf[0] : low_ovf[1];

    // ****************************************************************
    // read path
    // ****************************************************************

    logic [7:0] ctrl_view;
    logic [7:0] clk_view;
    logic [7:0] rd_mux;
    logic [7:0] rdata_q;

    assign ctrl_view = {4'h0, flag_q, run_q};
    assign clk_view = {3'h0, turbo_q, 3'h0};
    // unmapped offsets read zero
    assign rd_mux = (reg_addr_i == `TMR_OFS_MODE) ? mode_cfg_q
        : (reg_addr_i == `TMR_OFS_CTRL) ? ctrl_view
        : (reg_addr_i == `TMR_OFS_CLK) ? clk_view
        : (reg_addr_i == `TMR_OFS_LOW0) ? lo_q[0]
        : (reg_addr_i == `TMR_OFS_HIGH0) ? hi_q[0]
        : (reg_addr_i == `TMR_OFS_LOW1) ? lo_q[1]
        : (reg_addr_i == `TMR_OFS_HIGH1) ? hi_q[1]
        : `TMR_RST_BYTE;

    // read data shows only in the cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= `TMR_RST_BYTE;
        end else if (clk_en_i) begin
            rdata_q <= reg_rd_i ? rd_mux : `TMR_RST_BYTE;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign overflow_flag_o = flag_q;

endmodule // dual_timer

// File: sim/timer_checker_assertions.sv
`timescale 1ns/1ps
`include "timer_cfg.svh"
// ********
// port checker
// ********
module timer_checker (
    // watched ports
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic [`TMR_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [1:0] count_pin_i,
    input wire logic [1:0] ext_gate_pin_i,
    input wire logic [1:0] vector_ack_i,
    input wire logic [1:0] overflow_flag_o
);
    logic [7:0] mode_q;
    logic [7:0] clk_q;
    logic [1:0] run_q;
    logic [1:0] ph_q;
    wire wr_tk = reg_wr_i && clk_en_i;
    // shadows of software bits; the phase runs only on enabled clocks
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q <= 8'h00;
            clk_q <= 8'h00;
            run_q <= 2'h0;
            ph_q <= 2'h0;
        end else begin
            if (wr_tk && reg_addr_i == `TMR_OFS_MODE) mode_q <= reg_wdata_i;
            if (wr_tk && reg_addr_i == `TMR_OFS_CLK) clk_q <= reg_wdata_i;
            if (wr_tk && reg_addr_i == `TMR_OFS_CTRL) run_q <= reg_wdata_i[1:0];
            if (clk_en_i) ph_q <= ph_q + 2'h1;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    mode_back_a: assert property ($past(reg_rd_i && reg_addr_i == `TMR_OFS_MODE)
        |-> reg_rdata_o == mode_q) else $error("mode readback wrong");
    clk_back_a: assert property ($past(reg_rd_i && reg_addr_i == `TMR_OFS_CLK)
        |-> reg_rdata_o == (clk_q & 8'h18)) else $error("clock config readback wrong");
    run_back_a: assert property ($past(reg_rd_i && reg_addr_i == `TMR_OFS_CTRL)
        |-> reg_rdata_o[1:0] == run_q) else $error("run bits readback wrong");
    flag_phase_a: assert property ((overflow_flag_o & ~$past(overflow_flag_o)) != 2'h0
        && !$past(reg_wr_i) |-> ph_q == 2'h3) else $error("flag set off phase three");
    flag0_run_a: assert property ($rose(overflow_flag_o[0]) && !$past(reg_wr_i)
        |-> $past(run_q[0]) || $past(run_q[0], 2)) else $error("flag0 set while stopped");
    flag1_run_a: assert property ($rose(overflow_flag_o[1]) && !$past(reg_wr_i)
        |-> $past(run_q[1]) || $past(run_q[1], 2)) else $error("flag1 set while stopped");
    flag_sticky_a: assert property (overflow_flag_o[0] && !vector_ack_i[0] && !reg_wr_i
        |=> overflow_flag_o[0]) else $error("flag0 dropped without cause");
    frozen_unit_a: assert property ($past(mode_q[5:4]) == 2'h3 && $past(mode_q[1:0]) != 2'h3
        && !$past(reg_wr_i) |-> !$rose(overflow_flag_o[1])) else $error("frozen unit overflowed");
    cover property ($rose(overflow_flag_o[0]));
    cover property ($rose(overflow_flag_o[1]));
    cover property (reg_rd_i && reg_addr_i == 3'h7);
endmodule // timer_checker

bind dual_timer timer_checker u_timer_checker (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .count_pin_i(count_pin_i), .ext_gate_pin_i(ext_gate_pin_i),
    .vector_ack_i(vector_ack_i), .overflow_flag_o(overflow_flag_o));

// File: sim/pin_partner.sv
`timescale 1ns/1ps
// ********
// external pin source
// ********
module pin_partner (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // bench requests
    input wire logic [1:0] pulse_req_i,
    input wire logic [1:0] gate_lvl_i,
    // pins toward the block
    output logic [1:0] count_pin_o,
    output logic [1:0] ext_gate_pin_o
);
    assign ext_gate_pin_o = gate_lvl_i;
    for (genvar u = 0; u < 2; u++) begin : g_unit
        logic [4:0] cnt_q;
        // low 8 clocks then high: two samples per level; the bench spaces requests 24 clocks
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                cnt_q <= 5'h00;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
            end else if (pulse_req_i[u]) begin
                cnt_q <= 5'h10;
            end
        end
        assign count_pin_o[u] = !(cnt_q > 5'h08);
    end
endmodule // pin_partner

// File: sim/dual_timer_tb_top.sv
`timescale 1ns/1ps
`include "timer_cfg.svh"
// ********
// bench top
// ********
module dual_timer_tb_top;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [`TMR_ADDR_W-1:0] reg_addr_i = '0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [1:0] vector_ack_i = 2'h0;
    logic [1:0] pulse_req = 2'h0;
    logic [1:0] gate_lvl = 2'h0;
    logic clk_en = 1'b1;
    logic [1:0] count_pin_i, ext_gate_pin_i, overflow_flag_o;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    dual_timer u_dual_timer (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .count_pin_i(count_pin_i),
        .ext_gate_pin_i(ext_gate_pin_i), .vector_ack_i(vector_ack_i),
        .overflow_flag_o(overflow_flag_o));
    pin_partner u_pin_partner (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .pulse_req_i(pulse_req), .gate_lvl_i(gate_lvl), .count_pin_o(count_pin_i),
        .ext_gate_pin_o(ext_gate_pin_i));
    task automatic end_sim();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // strobes start two edges apart so no signal is assigned twice in a step
    task automatic wr(input int a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= 3'(a);
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input int a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= 3'(a);
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        chk8(reg_rdata_o, exp);
    endtask
    task automatic ack(input logic [1:0] m);
        @(posedge clk_sys_i);
        vector_ack_i <= m;
        @(posedge clk_sys_i);
        vector_ack_i <= 2'h0;
        #1;
        chk8({6'h00, overflow_flag_o & m}, 8'h00);
    endtask
    task automatic wait_flag(input logic [1:0] m, output int n);
        n = 0;
        while ((overflow_flag_o & m) !== m && n < 400) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        chk8({6'h00, overflow_flag_o & m}, {6'h00, m});
    endtask
    // interval between two overflows, counted from the ack edge pair
    task automatic period(input logic [7:0] exp);
        int n;
        wait_flag(2'b01, n);
        ack(2'b01);
        wait_flag(2'b01, n);
        chk8(8'(n + 2), exp);
    endtask
    task automatic pulses(input logic [1:0] m, input int k);
        repeat (k) begin
            @(posedge clk_sys_i);
            pulse_req <= m;
            @(posedge clk_sys_i);
            pulse_req <= 2'h0;
            repeat (22) @(posedge clk_sys_i);
        end
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin : main
        int n;
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        wr(0, 8'h02);
        wr(4, 8'hfe);
        wr(3, 8'hfe);
        wr(1, 8'h01);
        period(8'h18);
        wr(1, 8'h00);
        wr(2, 8'h08);
        wr(1, 8'h01);
        period(8'h08);
        wr(1, 8'h00);
        rd(4, 8'hfe);
        wr(0, 8'h00);
        wr(4, 8'hff);
        wr(3, 8'hff);
        wr(1, 8'h01);
        wait_flag(2'b01, n);
        wr(1, 8'h00);
        rd(3, 8'he0);
        rd(4, 8'h00);
        wr(0, 8'hd0);
        wr(5, 8'h00);
        wr(6, 8'h00);
        wr(1, 8'h02);
        pulses(2'b10, 2);
        rd(5, 8'h00);
        @(posedge clk_sys_i);
        gate_lvl <= 2'b10;
        pulses(2'b10, 3);
        rd(5, 8'h03);
        wr(5, 8'hff);
        wr(6, 8'hff);
        pulses(2'b10, 1);
        chk8({6'h00, overflow_flag_o}, 8'h02);
        ack(2'b10);
        rd(6, 8'h00);
        wr(1, 8'h00);
        wr(0, 8'h30);
        wr(5, 8'h55);
        wr(4, 8'hff);
        wr(0, 8'h33);
        wr(1, 8'h02);
        wait_flag(2'b10, n);
        chk8({6'h00, overflow_flag_o}, 8'h02);
        wr(1, 8'h00);
        rd(5, 8'h55);
        rd(4, 8'h00);
        // enable low must hold a count one tick from rolling over
        wr(0, 8'h01);
        wr(4, 8'hff);
        wr(3, 8'hff);
        wr(1, 8'h01);
        clk_en <= 1'b0;
        repeat (40) @(posedge clk_sys_i);
        chk8({6'h00, overflow_flag_o}, 8'h00);
        clk_en <= 1'b1;
        wait_flag(2'b01, n);
        end_sim();
    end
endmodule // dual_timer_tb_top
